// File: src/cbm_pkg.sv
// Behaviour
// - Mask A codes 1111..1100 pick fault 4, fault 2, trigger out 19, 18.
// - Codes 4..0 pick PWM3 low, PWM2 high/low, PWM1 high/low; rest reserved.
// - Level select 1 blocks low-asserted comparator; 0 blocks high-asserted.
// - OR C true enable connects mask C to the OR gate.
// - OR C inverted enable connects inverted mask C to the OR gate.
// - OR B true enable connects mask B to the OR gate.
// - OR B inverted enable connects inverted mask B to the OR gate.
// - OR A true enable connects mask A to the OR gate.
// - OR A inverted enable connects inverted mask A to the OR gate.
// - AND output enable feeds the AND result into the OR gate.
// - Inverted AND output enable feeds inverted AND result into the OR gate.
// - Six enables connect A, B, C true and inverted to the AND gate.
package cbm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CBM_SRC_ADDR  = 12'h000;
  localparam logic [11:0] CBM_GATE_ADDR = 12'h004;
  localparam logic [11:0] CBM_STAT_ADDR = 12'h008;
  localparam logic [15:0] CBM_SRC_WMASK  = 16'h000F;
  localparam logic [15:0] CBM_GATE_WMASK = 16'hBFFF;
  localparam logic [15:0] CBM_REG_RESET  = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CBM_SELA_LSB   = 0;
  localparam int CBM_BLANK_LVL  = 15;
  localparam int CBM_OR_C_TRUE  = 13;
  localparam int CBM_OR_C_INV   = 12;
  localparam int CBM_OR_B_TRUE  = 11;
  localparam int CBM_OR_B_INV   = 10;
  localparam int CBM_OR_A_TRUE  = 9;
  localparam int CBM_OR_A_INV   = 8;
  localparam int CBM_AND_O_INV  = 7;
  localparam int CBM_AND_O_TRUE = 6;
  localparam int CBM_AND_C_TRUE = 5;
  localparam int CBM_AND_C_INV  = 4;
  localparam int CBM_AND_B_TRUE = 3;
  localparam int CBM_AND_B_INV  = 2;
  localparam int CBM_AND_A_TRUE = 1;
  localparam int CBM_AND_A_INV  = 0;

  // ----------------------------------------------------------------
  // Mask A source codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CBM_SEL_FAULT4 = 4'hF;
  localparam logic [3:0] CBM_SEL_FAULT2 = 4'hE;
  localparam logic [3:0] CBM_SEL_TRIG19 = 4'hD;
  localparam logic [3:0] CBM_SEL_TRIG18 = 4'hC;
  localparam logic [3:0] CBM_SEL_PWM3_LO = 4'h4;
  localparam logic [3:0] CBM_SEL_PWM2_HI = 4'h3;
  localparam logic [3:0] CBM_SEL_PWM2_LO = 4'h2;
  localparam logic [3:0] CBM_SEL_PWM1_HI = 4'h1;
  localparam logic [3:0] CBM_SEL_PWM1_LO = 4'h0;

endpackage : cbm_pkg

// File: src/cbm_cfg_if.sv
`timescale 1ns/10ps
// Carries register contents from the bus slave to the gate network
interface cbm_cfg_if;
  logic [3:0]  maskASel;
  logic [15:0] gateCtl;
  modport regs (output maskASel, output gateCtl);
  modport gate (input maskASel, input gateCtl);
endinterface : cbm_cfg_if

// File: src/cbm_apb_regs.sv
`timescale 1ns/10ps
module cbm_apb_regs
  import cbm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic [1:0]  maskState,
  cbm_cfg_if.regs          cfg
);

  logic [15:0] srcReg_q;
  logic [15:0] gateReg_q;
  logic        wrEn;
  logic [15:0] laneMask;

  assign wrEn     = psel && penable && pwrite;
  assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcReg_q <= CBM_REG_RESET;
    end else if (wrEn && paddr == CBM_SRC_ADDR) begin
      srcReg_q <= (srcReg_q & ~(laneMask & CBM_SRC_WMASK))
                | (pwdata[15:0] & laneMask & CBM_SRC_WMASK);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gateReg_q <= CBM_REG_RESET;
    end else if (wrEn && paddr == CBM_GATE_ADDR) begin
      gateReg_q <= (gateReg_q & ~(laneMask & CBM_GATE_WMASK))
                 | (pwdata[15:0] & laneMask & CBM_GATE_WMASK);
    end
  end

  // Zero-wait slave: read data is combinational on the current address
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == CBM_SRC_ADDR) begin
      prdata = {16'h0000, srcReg_q};
    end else if (paddr == CBM_GATE_ADDR) begin
      prdata = {16'h0000, gateReg_q};
    end else if (paddr == CBM_STAT_ADDR) begin
      prdata = {30'h0000_0000, maskState};
    end else begin
      pslverr = psel && penable;
    end
  end

  assign cfg.maskASel = srcReg_q[CBM_SELA_LSB +: 4];
  assign cfg.gateCtl  = gateReg_q;

endmodule : cbm_apb_regs

// File: src/cbm_blank_top.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
module cbm_blank_top
  import cbm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        compIn,
  input  wire logic        pwmGen1Low,
  input  wire logic        pwmGen1High,
  input  wire logic        pwmGen2Low,
  input  wire logic        pwmGen2High,
  input  wire logic        pwmGen3Low,
  input  wire logic        trigGenOut18,
  input  wire logic        trigGenOut19,
  input  wire logic        faultInTwo,
  input  wire logic        faultInFour,
  input  wire logic        maskInputB,
  input  wire logic        maskInputC,
  output logic             compOut,
  output logic             activeMask
);

  cbm_cfg_if cfg ();

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;

  assign rawIn = {compIn, maskInputC, maskInputB, faultInFour, faultInTwo,
                  trigGenOut19, trigGenOut18, pwmGen3Low, pwmGen2High,
                  pwmGen2Low, pwmGen1High, pwmGen1Low};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= rawIn;
      sync_q <= meta_q;
    end
  end

  logic maskA;
  logic maskB;
  logic maskC;
  logic compSync;
  logic [15:0] gc;
  logic andTerm;
  logic orTerm;
  logic blankLvl;

  assign maskB    = sync_q[9];
  assign maskC    = sync_q[10];
  assign compSync = sync_q[11];
  assign gc       = cfg.gateCtl;
  assign blankLvl = gc[CBM_BLANK_LVL];

  // ----------------------------------------------------------------
  // Mask A source select
  // ----------------------------------------------------------------
  function automatic logic selMaskA(input logic [3:0] code, input logic [NSYNC-1:0] s);
    logic r;
    r = 1'b0;
    case (code)
      CBM_SEL_FAULT4: r = s[8];
      CBM_SEL_FAULT2: r = s[7];
      CBM_SEL_TRIG19: r = s[6];
      CBM_SEL_TRIG18: r = s[5];
      CBM_SEL_PWM3_LO: r = s[4];
      CBM_SEL_PWM2_HI: r = s[3];
      CBM_SEL_PWM2_LO: r = s[2];
      CBM_SEL_PWM1_HI: r = s[1];
      CBM_SEL_PWM1_LO: r = s[0];
      default:        r = 1'b0; // Reserved codes hold mask A low
    endcase
    return r;
  endfunction : selMaskA

  assign maskA = selMaskA(cfg.maskASel, sync_q);

  // ----------------------------------------------------------------
  // Gate network
  // ----------------------------------------------------------------
  // A disabled leg contributes a 1; with no leg enabled the AND is 1,
  // so software must enable AND legs before using the AND output.
  assign andTerm = (maskA  | ~gc[CBM_AND_A_TRUE]) & (~maskA | ~gc[CBM_AND_A_INV])
                 & (maskB  | ~gc[CBM_AND_B_TRUE]) & (~maskB | ~gc[CBM_AND_B_INV])
                 & (maskC  | ~gc[CBM_AND_C_TRUE]) & (~maskC | ~gc[CBM_AND_C_INV]);

  assign orTerm = (maskC & gc[CBM_OR_C_TRUE])
                | (~maskC & gc[CBM_OR_C_INV])
                | (maskB & gc[CBM_OR_B_TRUE])
                | (~maskB & gc[CBM_OR_B_INV])
                | (maskA & gc[CBM_OR_A_TRUE])
                | (~maskA & gc[CBM_OR_A_INV])
                | (andTerm & gc[CBM_AND_O_TRUE])
                | (~andTerm & gc[CBM_AND_O_INV]);

  // Registered outputs: one cycle after the synchronised inputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      activeMask <= 1'b0;
    end else begin
      activeMask <= orTerm;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      compOut <= 1'b0;
    end else if (orTerm) begin
      compOut <= blankLvl;
    end else begin
      compOut <= compSync;
    end
  end

  assign pready = 1'b1;

  cbm_apb_regs u_regs (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pstrb     (pstrb),
    .prdata    (prdata),
    .pslverr   (pslverr),
    .maskState ({compOut, activeMask}),
    .cfg       (cfg.regs)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Level select is taken at the edge that launched compOut, not the current one
  blank_high_a: assert property ($past(orTerm) && !$past(blankLvl) |-> !compOut)
    else $error("high-asserted comparator not blanked");
  blank_low_a: assert property ($past(orTerm) && $past(blankLvl) |-> compOut)
    else $error("low-asserted comparator not blanked");
  pass_thru_a: assert property (!orTerm |=> compOut == $past(compSync))
    else $error("comparator not passed when unmasked");
  or_a_true_a: assert property (gc[CBM_OR_A_TRUE] && maskA |=> activeMask)
    else $error("mask A true leg ignored");
  or_a_inv_a: assert property (gc[CBM_OR_A_INV] && !maskA |=> activeMask)
    else $error("mask A inverted leg ignored");
  or_b_true_a: assert property (gc[CBM_OR_B_TRUE] && maskB |=> activeMask)
    else $error("mask B true leg ignored");
  or_b_inv_a: assert property (gc[CBM_OR_B_INV] && !maskB |=> activeMask)
    else $error("mask B inverted leg ignored");
  or_c_true_a: assert property (gc[CBM_OR_C_TRUE] && maskC |=> activeMask)
    else $error("mask C true leg ignored");
  or_c_inv_a: assert property (gc[CBM_OR_C_INV] && !maskC |=> activeMask)
    else $error("mask C inverted leg ignored");
  and_out_a: assert property (gc[CBM_AND_O_TRUE] && andTerm |=> activeMask)
    else $error("AND output leg ignored");
  and_inv_a: assert property (gc[CBM_AND_O_INV] && !andTerm |=> activeMask)
    else $error("inverted AND output leg ignored");
  and_leg_a: assert property (gc[CBM_AND_A_TRUE] && !maskA |-> !andTerm)
    else $error("AND gate ignores mask A");
  sel_fault_a: assert property (cfg.maskASel == CBM_SEL_FAULT4 |-> maskA == sync_q[8])
    else $error("fault 4 not selected");
  sel_pwm_a: assert property (cfg.maskASel == CBM_SEL_PWM1_LO |-> maskA == sync_q[0])
    else $error("PWM1 low not selected");

  blank_cov: cover property (orTerm && compSync ##1 !compOut);
  pass_cov:  cover property (!orTerm ##1 compOut);
  and_cov:   cover property (gc[CBM_AND_O_TRUE] && andTerm);

endmodule : cbm_blank_top

// File: testbench/cbm_src_model.sv
`timescale 1ns/10ps
// Comparator and mask sources; each level changes only at a clock edge
module cbm_src_model (
  input  wire logic        core_clk,
  input  wire logic [11:0] want,
  output logic      [11:0] srcBus
);
  always_ff @(posedge core_clk) begin
    srcBus <= want;
  end
endmodule : cbm_src_model

// File: testbench/cbm_blank_top_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errTotal++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module cbm_blank_top_bench;
  import cbm_pkg::*;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000, want = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF, sel;
  logic [15:0] gate;
  logic [11:0] srcBus;
  logic        pready, pslverr, compOut, activeMask, err;
  int          errTotal = 0, checked = 0, cycles = 0, seed = 32'h68ad;
  logic [3:0]  codes [9] = '{CBM_SEL_FAULT4, CBM_SEL_FAULT2, CBM_SEL_TRIG19, CBM_SEL_TRIG18,
                             CBM_SEL_PWM3_LO, CBM_SEL_PWM2_HI, CBM_SEL_PWM2_LO,
                             CBM_SEL_PWM1_HI, CBM_SEL_PWM1_LO};
  always #5 core_clk = ~core_clk;
  cbm_src_model model (.core_clk(core_clk), .want(want), .srcBus(srcBus));
  cbm_blank_top dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compIn(srcBus[0]), .pwmGen1Low(srcBus[1]),
    .pwmGen1High(srcBus[2]), .pwmGen2Low(srcBus[3]), .pwmGen2High(srcBus[4]),
    .pwmGen3Low(srcBus[5]), .trigGenOut18(srcBus[6]), .trigGenOut19(srcBus[7]),
    .faultInTwo(srcBus[8]), .faultInFour(srcBus[9]), .maskInputB(srcBus[10]),
    .maskInputC(srcBus[11]), .compOut(compOut), .activeMask(activeMask));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task closeOut;
    $display("errors %0d, comparisons %0d", errTotal, checked);
    if (errTotal == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : closeOut
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      closeOut;
    end
  end
  // Waits on pready without assuming the slave's latency; only the bench timeout ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Returns {compOut, activeMask} for given config and source levels
  function automatic logic [1:0] expOut(logic [3:0] s, logic [15:0] g, logic [11:0] v);
    logic a, an, m;
    logic [5:0] lg;
    a  = (s <= 4'h4) ? v[s + 1] : (s >= 4'hC) ? v[s - 6] : 1'b0;
    lg = {v[11], ~v[11], v[10], ~v[10], a, ~a};
    an = &(lg | ~g[5:0]);
    m  = |({lg, ~an, an} & g[13:6]);
    return {m ? g[15] : v[0], m};
  endfunction : expOut
  task setAndCheck(input logic [3:0] s, input logic [15:0] g, input logic [11:0] v);
    apb(1'b1, CBM_SRC_ADDR, {28'h0, s});
    apb(1'b1, CBM_GATE_ADDR, {16'h0, g});
    want <= v;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK({compOut, activeMask}, expOut(s, g, v))
    apb(1'b0, CBM_STAT_ADDR, 32'h0);
    `CHK(rd, {30'h0, expOut(s, g, v)})
    `CHK(err, 1'b0)
  endtask : setAndCheck
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, CBM_SRC_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, CBM_GATE_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, CBM_SRC_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, CBM_SRC_ADDR, 32'h0);
    `CHK(rd[15:0], CBM_SRC_WMASK)
    apb(1'b1, CBM_GATE_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, CBM_GATE_ADDR, 32'h0);
    `CHK(rd[15:0], CBM_GATE_WMASK)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(err, 1'b1)
    // Each source code with all sources low, then all mask sources high, through OR leg A, then only the comparator high through inverted leg A
    for (int i = 0; i < 9; i++) begin
      setAndCheck(codes[i], 16'h0200, 12'h000);
      setAndCheck(codes[i], 16'h0200, 12'hFFE);
      setAndCheck(codes[i], 16'h8100, 12'h001);
    end
    setAndCheck(4'h7, 16'h0200, 12'hFFF);
    setAndCheck(4'h0, 16'h0040, 12'h000);
    setAndCheck(4'h0, 16'h0080, 12'hC02);
    for (int i = 0; i < 300; i++) begin
      sel  = 4'($random(seed));
      gate = 16'($random(seed)) & CBM_GATE_WMASK;
      setAndCheck(sel, gate, 12'($random(seed)));
    end
    closeOut;
  end
endmodule : cbm_blank_top_bench
